/* include/csrs_pkg.sv */
// Package: special-register map, flag layout, ALU opcodes, datapath struct
package csrs_pkg;

  // ==========================================================
  // Register indices (byte address on the bus is four times these)
  localparam logic [7:0] CSRS_IDX_IND0 = 8'h00;
  localparam logic [7:0] CSRS_IDX_MP0 = 8'h01;
  localparam logic [7:0] CSRS_IDX_IND1 = 8'h02;
  localparam logic [7:0] CSRS_IDX_MP1 = 8'h03;
  localparam logic [7:0] CSRS_IDX_ACC = 8'h05;
  localparam logic [7:0] CSRS_IDX_PCL = 8'h06;
  localparam logic [7:0] CSRS_IDX_TABLE_PTR_LOW = 8'h07;
  localparam logic [7:0] CSRS_IDX_TABLE_DATA_HIGH = 8'h08;
  localparam logic [7:0] CSRS_IDX_TABLE_PTR_HIGH = 8'h09;
  localparam logic [7:0] CSRS_IDX_FLAGS = 8'h0A;
  localparam logic [7:0] CSRS_GP_BASE = 8'h40;

  // ==========================================================
  // Flag bit positions inside cpu_flags
  localparam int CSRS_FLG_C = 0;
  localparam int CSRS_FLG_AC = 1;
  localparam int CSRS_FLG_Z = 2;
  localparam int CSRS_FLG_OV = 3;
  localparam int CSRS_FLG_PDF = 4;
  localparam int CSRS_FLG_TO = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CSRS_BYTE_RST = 8'h00;
  localparam logic [5:0] CSRS_FLAGS_RST = 6'h00;

  // ==========================================================
  // ALU operations requested by the datapath
  typedef enum logic [2:0]
  {
    CSRS_OP_NONE = 3'b000,
    CSRS_OP_ADD = 3'b001,
    CSRS_OP_SUB = 3'b010,
    CSRS_OP_AND = 3'b011,
    CSRS_OP_OR = 3'b100,
    CSRS_OP_XOR = 3'b101,
    CSRS_OP_RLC = 3'b110,
    CSRS_OP_RRC = 3'b111
  } csrs_op_e;

  // One cycle of datapath commands
  typedef struct packed {
    csrs_op_e op;
    logic [7:0] operand;
    logic store_go;
    logic [7:0] store_idx;
    logic tbl_go;
    logic [7:0] tbl_idx;
    logic pc_step;
    logic watchdog_clear_instr;
    logic halt;
    logic wdt_timeout;
  } csrs_dp_s;

endpackage

/* core/csrs_core.sv */
// Core special registers: pointers, accumulator, PC low, table, flags
// Function
// - Indirect ports redirect through their pointers
// - Indirect port via pointer: read zero, write ignored
// - Small variant: pointer bit seven reads one
// - Pointers are ordinary read/write registers
// - ALU results land in accumulator only
// - PC low write replaces low byte only
// - PC low write adds one dummy cycle
// - Table read: high byte latched, low stored
// - Status writes never touch system flags
// - Timeout flag: set by watchdog, cleared by halt or watchdog-clear
// - Power-down flag: halt sets, watchdog-clear clears
// - Carry: add carry, subtract no-borrow, rotates
// - Half carry from low nibble
// - Zero flag follows add, subtract and logic results; rotates leave it
// - Overflow: carry in differs carry out
// - Status bits seven, six read zero
// - System flags zero after power-on
// - Status never pushed on call/interrupt
// - Registers at fixed low addresses
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
module csrs_core
  import csrs_pkg::*;
#(
  parameter int RAM_DEPTH = 64,
  parameter int PC_W = 13,
  parameter bit SMALL_VARIANT = 1'b1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire csrs_dp_s dp,
  input wire logic [15:0] pm_rdata,
  output logic [15:0] pm_addr,
  output logic [PC_W-1:0] pc_out,
  output logic dummy_cycle,
  output logic [7:0] acc_out,
  output logic [7:0] flags_out
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [RAM_DEPTH-1:0][7:0] ram;
    logic [PC_W-1:0] pc;
    logic [7:0] acc;
    logic [7:0] mp0;
    logic [7:0] mp1;
    logic [7:0] table_ptr_low;
    logic [7:0] table_ptr_high;
    logic [7:0] table_data_high;
    logic [5:0] flags;
    logic dummy;
    logic wr_pend;
    logic [7:0] widx;
    logic [7:0] rdata;
  } csrs_state_s;

  csrs_state_s st_reg;
  csrs_state_s st_next;

  // ==========================================================
  // Decoding helpers

  // Pointer as an address; small variant ignores bit seven
  function automatic logic [7:0] ptr_addr(logic [7:0] mp);
    ptr_addr = SMALL_VARIANT ? {1'b0, mp[6:0]} : mp;
  endfunction

  // Resolves an index to a target; bit 8 low means no target
  function automatic logic [8:0] resolve(csrs_state_s s, logic [7:0] idx);
    logic [7:0] a;
    logic ind;
    a = idx;
    ind = 1'b0;
    if (idx == CSRS_IDX_IND0)
    begin
      a = ptr_addr(s.mp0);
      ind = 1'b1;
    end
    else if (idx == CSRS_IDX_IND1)
    begin
      a = ptr_addr(s.mp1);
      ind = 1'b1;
    end
    // Port reached through a pointer has no storage behind it
    resolve = {!(ind && (a == CSRS_IDX_IND0 || a == CSRS_IDX_IND1)), a};
  endfunction

  // General-purpose RAM hit test
  function automatic logic ram_hit(logic [7:0] a);
    logic [7:0] off;
    off = a - CSRS_GP_BASE;
    ram_hit = (a >= CSRS_GP_BASE) && (int'(off) < RAM_DEPTH);
  endfunction

  // Byte read through the data-memory view
  function automatic logic [7:0] rd(csrs_state_s s, logic [7:0] idx);
    logic [8:0] r;
    logic [7:0] a;
    r = resolve(s, idx);
    a = r[7:0];
    rd = 8'h00;
    if (r[8])
    begin
      case (a)
        CSRS_IDX_MP0: rd = SMALL_VARIANT ? {1'b1, s.mp0[6:0]} : s.mp0;
        CSRS_IDX_MP1: rd = SMALL_VARIANT ? {1'b1, s.mp1[6:0]} : s.mp1;
        CSRS_IDX_ACC: rd = s.acc;
        CSRS_IDX_PCL: rd = s.pc[7:0];
        CSRS_IDX_TABLE_PTR_LOW: rd = s.table_ptr_low;
        CSRS_IDX_TABLE_DATA_HIGH: rd = s.table_data_high;
        CSRS_IDX_TABLE_PTR_HIGH: rd = s.table_ptr_high;
        CSRS_IDX_FLAGS: rd = {2'b00, s.flags};
        default:
        begin
          if (ram_hit(a))
            rd = s.ram[a - CSRS_GP_BASE];
        end
      endcase
    end
  endfunction

  // Byte write through the data-memory view
  function automatic csrs_state_s wr(csrs_state_s s, logic [7:0] idx,
                                     logic [7:0] d);
    logic [8:0] r;
    logic [7:0] a;
    r = resolve(s, idx);
    a = r[7:0];
    wr = s;
    if (r[8])
    begin
      case (a)
        CSRS_IDX_MP0: wr.mp0 = d;
        CSRS_IDX_MP1: wr.mp1 = d;
        CSRS_IDX_ACC: wr.acc = d;
        CSRS_IDX_PCL:
        begin
          wr.pc[7:0] = d;
          wr.dummy = 1'b1;
        end
        CSRS_IDX_TABLE_PTR_LOW: wr.table_ptr_low = d;
        CSRS_IDX_TABLE_PTR_HIGH: wr.table_ptr_high = d;
        CSRS_IDX_FLAGS: wr.flags[3:0] = d[3:0];
        default:
        begin
          if (ram_hit(a))
            wr.ram[a - CSRS_GP_BASE] = d;
        end
      endcase
    end
  endfunction

  // ==========================================================
  // Next state
  logic [7:0] bb;
  logic cin;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] low7;
  logic [7:0] res;
  logic upd_z;
  logic mapped;

  // Bus is handled first so the datapath wins a same-cycle conflict, except a bus PC low write, which cancels the step
  always_comb
  begin
    st_next = st_reg;
    st_next.dummy = 1'b0;
    bb = dp.operand;
    cin = 1'b0;
    res = st_reg.acc;
    upd_z = 1'b0;
    if (st_reg.wr_pend)
      st_next = wr(st_next, st_reg.widx, hwdata[7:0]);
    // Adder shared by add and subtract (subtract adds ~b plus one)
    if (dp.op == CSRS_OP_SUB)
    begin
      bb = ~dp.operand;
      cin = 1'b1;
    end
    sum = {1'b0, st_reg.acc} + {1'b0, bb} + {8'h00, cin};
    nib = {1'b0, st_reg.acc[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    low7 = {1'b0, st_reg.acc[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
    // Flags land in the same cycle as the accumulator result
    case (dp.op)
      CSRS_OP_ADD, CSRS_OP_SUB:
      begin
        res = sum[7:0];
        upd_z = 1'b1;
        st_next.flags[CSRS_FLG_C] = sum[8];
        st_next.flags[CSRS_FLG_AC] = nib[4];
        st_next.flags[CSRS_FLG_OV] = sum[8] ^ low7[7];
      end
      CSRS_OP_AND:
      begin
        res = st_reg.acc & dp.operand;
        upd_z = 1'b1;
      end
      CSRS_OP_OR:
      begin
        res = st_reg.acc | dp.operand;
        upd_z = 1'b1;
      end
      CSRS_OP_XOR:
      begin
        res = st_reg.acc ^ dp.operand;
        upd_z = 1'b1;
      end
      CSRS_OP_RLC:
      begin
        res = {st_reg.acc[6:0], st_reg.flags[CSRS_FLG_C]};
        st_next.flags[CSRS_FLG_C] = st_reg.acc[7];
      end
      CSRS_OP_RRC:
      begin
        res = {st_reg.flags[CSRS_FLG_C], st_reg.acc[7:1]};
        st_next.flags[CSRS_FLG_C] = st_reg.acc[0];
      end
      default:
      begin
        res = st_next.acc;
      end
    endcase
    if (dp.op != CSRS_OP_NONE)
      st_next.acc = res;
    if (upd_z)
      st_next.flags[CSRS_FLG_Z] = (res == 8'h00);
    // Register-to-register moves only go through the accumulator
    if (dp.store_go)
      st_next = wr(st_next, dp.store_idx, st_reg.acc);
    // Table fetch uses the pointers as they stand this cycle
    if (dp.tbl_go)
    begin
      st_next.table_data_high = pm_rdata[15:8];
      st_next = wr(st_next, dp.tbl_idx, pm_rdata[7:0]);
    end
    // A jump replaces the normal step
    if (dp.pc_step && !st_next.dummy)
      st_next.pc = st_reg.pc + {{(PC_W-1){1'b0}}, 1'b1};
    // System flags: set beats clear when both arrive together
    if (dp.watchdog_clear_instr || dp.halt)
      st_next.flags[CSRS_FLG_TO] = 1'b0;
    if (dp.wdt_timeout)
      st_next.flags[CSRS_FLG_TO] = 1'b1;
    if (dp.watchdog_clear_instr)
      st_next.flags[CSRS_FLG_PDF] = 1'b0;
    if (dp.halt)
      st_next.flags[CSRS_FLG_PDF] = 1'b1;
    // Bus address phase; read data sampled after this cycle's updates
    mapped = (haddr[31:10] == 22'h000000);
    st_next.wr_pend = hsel && htrans[1] && hready && hwrite && mapped;
    st_next.widx = haddr[9:2];
    if (hsel && htrans[1] && hready && !hwrite)
      st_next.rdata = mapped ? rd(st_next, haddr[9:2]) : 8'h00;
  end

  // State register; arithmetic flags have no defined value, zero chosen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '0;
      st_reg.flags <= CSRS_FLAGS_RST;
      st_reg.acc <= CSRS_BYTE_RST;
    end
    else
      st_reg <= st_next;
  end

  // ==========================================================
  // Outputs, all from the state register
  assign hrdata = {24'h000000, st_reg.rdata};
  assign hreadyout = st_reg.wr_pend | ~st_reg.wr_pend; // Zero wait states
  assign hresp = st_reg.dummy & 1'b0; // Always OKAY
  assign pm_addr = {st_reg.table_ptr_high, st_reg.table_ptr_low};
  assign pc_out = st_reg.pc;
  assign dummy_cycle = st_reg.dummy;
  assign acc_out = st_reg.acc;
  assign flags_out = {2'b00, st_reg.flags};
  // Flags live only here; no stack path exists for them

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic rd_req;
  logic [8:0] ind0_res;
  assign rd_req = hsel && htrans[1] && hready && !hwrite;
  // Where the first port lands this cycle; bit 8 low means no storage
  assign ind0_res = resolve(st_next, CSRS_IDX_IND0);

  a_flags_hi_zero: assert property (flags_out[7:6] == 2'b00)
    else $error("status high bits not zero");

  a_to_on_timeout: assert property (dp.wdt_timeout |=> flags_out[5])
    else $error("timeout flag not set");

  a_to_clear: assert property ((dp.halt || dp.watchdog_clear_instr) && !dp.wdt_timeout
    |=> !flags_out[5])
    else $error("timeout flag not cleared");

  a_pdf_track: assert property (dp.halt |=> flags_out[4])
    else $error("power-down flag not set by halt");

  a_pdf_clear: assert property (dp.watchdog_clear_instr && !dp.halt |=> !flags_out[4])
    else $error("power-down flag not cleared");

  a_sys_flags_held: assert property (st_reg.wr_pend
    && st_reg.widx == CSRS_IDX_FLAGS && !dp.halt && !dp.watchdog_clear_instr
    && !dp.wdt_timeout |=> $stable(flags_out[5:4]))
    else $error("status write changed system flags");

  a_pcl_jump: assert property (st_reg.wr_pend && st_reg.widx == CSRS_IDX_PCL
    && dp.op == CSRS_OP_NONE && !dp.store_go && !dp.tbl_go
    |=> pc_out[7:0] == $past(hwdata[7:0]) && dummy_cycle
    && pc_out[PC_W-1:8] == $past(pc_out[PC_W-1:8]))
    else $error("program counter low write wrong");

  a_add_result: assert property (dp.op == CSRS_OP_ADD && !dp.tbl_go
    && !dp.store_go |=> {flags_out[0], acc_out}
    == $past({1'b0, acc_out}) + $past({1'b0, dp.operand}))
    else $error("add result or carry wrong");

  a_zero_flag: assert property (dp.op inside {CSRS_OP_ADD, CSRS_OP_SUB,
    CSRS_OP_AND, CSRS_OP_OR, CSRS_OP_XOR} && !dp.tbl_go && !dp.store_go
    |=> flags_out[2] == (acc_out == 8'h00))
    else $error("zero flag wrong");

  a_ind_self_zero: assert property (rd_req && haddr[31:2] == 30'h0
    && !ind0_res[8] |=> hrdata == 32'h0)
    else $error("self-indirect read not zero");

  a_mp_bit7: assert property (rd_req && SMALL_VARIANT
    && haddr[31:2] == {22'h0, CSRS_IDX_MP0} |=> hrdata[7])
    else $error("pointer bit seven not one");

  a_tbl_high: assert property (dp.tbl_go
    |=> st_reg.table_data_high == $past(pm_rdata[15:8]))
    else $error("table high byte not latched");

  c_add: cover property (dp.op == CSRS_OP_ADD ##1 flags_out[0]);
  c_halt: cover property (dp.halt ##1 flags_out[4]);
  c_jump: cover property (dummy_cycle);
  c_table: cover property (dp.tbl_go && dp.tbl_idx == CSRS_IDX_IND0);

endmodule // csrs_core

/* tb/test_cpu_special_regs_status.sv */
// Testbench for the special register block: bus, ALU, flags, PC, table
module test_cpu_special_regs_status
  import csrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, dummy_cycle;
  logic [31:0] haddr, hwdata, hrdata, rv, n;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] pm_rdata, pm_addr, w;
  logic [12:0] pc_out;
  logic [7:0] acc_out, flags_out, a, d;
  logic [11:0] e;
  logic [15:0] ctab [4] = '{16'h7F01, 16'h1001, 16'hFF01, 16'h8001};
  csrs_dp_s dp, s;
  int num_errors, checked;

  // ==========================================================
  // Reference functions
  // Program memory content is a fixed scramble of its address
  function automatic logic [15:0] pm_word(input logic [15:0] x);
    return {x[7:0] ^ 8'hA5, x[15:8] ^ 8'h3C};
  endfunction

  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction

  // Result and {ov, z, ac, c}; subtract is add of the complement plus one
  function automatic logic [11:0] alu(input csrs_op_e op,
    input logic [7:0] x, input logic [7:0] y, input logic [3:0] f);
    logic [8:0] t;
    logic [4:0] h;
    logic [7:0] m;
    logic [7:0] r;
    logic ci;
    ci = (op == CSRS_OP_SUB);
    r = ci ? ~y : y;
    t = 9'(x) + 9'(r) + 9'(ci);
    h = 5'(x[3:0]) + 5'(r[3:0]) + 5'(ci);
    m = 8'(x[6:0]) + 8'(r[6:0]) + 8'(ci);
    case (op)
      CSRS_OP_ADD, CSRS_OP_SUB:
        return {m[7] ^ t[8], t[7:0] == 8'h00, h[4], t[8], t[7:0]};
      CSRS_OP_AND: r = x & y;
      CSRS_OP_OR: r = x | y;
      CSRS_OP_XOR: r = x ^ y;
      CSRS_OP_RLC: return {f[3:1], x[7], x[6:0], f[0]};
      CSRS_OP_RRC: return {f[3:1], x[0], f[0], x[7:1]};
      default: r = x;
    endcase
    return {f[3], r == 8'h00, f[1:0], r};
  endfunction

  // ==========================================================
  // Design under test
  csrs_core #(.RAM_DEPTH(64), .PC_W(13), .SMALL_VARIANT(1'b1)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dp(dp), .pm_rdata(pm_rdata), .pm_addr(pm_addr),
    .pc_out(pc_out), .dummy_cycle(dummy_cycle), .acc_out(acc_out),
    .flags_out(flags_out)
  );

  // Clock, single-slave ready loop-back, combinational program memory
  always #5 hclk = ~hclk;
  assign hready = hreadyout;
  assign pm_rdata = pm_word(pm_addr);

  // ==========================================================
  // Tasks
  task automatic finish_test();
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    checked++;
    if (got !== x)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, x);
    end
  endtask

  // Bounded wait so a stuck ready cannot hang the run
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      k++;
      if (k > 20)
      begin
        num_errors++;
        $display("MISMATCH t=%0t bus ready timeout", $time);
        finish_test();
      end
      @(posedge hclk);
    end
  endtask

  // One single AHB-Lite transfer; read data taken at the data-phase edge
  task automatic bus(input logic wr_en, input logic [31:0] adr,
    input logic [7:0] x);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= adr;
    htrans <= 2'b10;
    hwrite <= wr_en;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= 32'(x);
    wait_rdy();
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] x);
    bus(1'b1, ad(i), x);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] x);
    bus(1'b0, ad(i), 8'h00);
    chk(rv, 32'(x));
  endtask

  // One-cycle datapath command; outputs settle after the next edge
  task automatic dp_go(input csrs_dp_s c);
    @(posedge hclk);
    dp <= c;
    @(posedge hclk);
    dp <= '0;
    #1;
  endtask

  task automatic sys(input logic h, input logic t, input logic c,
    input logic [7:0] x);
    s = '0;
    s.halt = h;
    s.wdt_timeout = t;
    s.watchdog_clear_instr = c;
    dp_go(s);
    chk(32'(flags_out), 32'(x));
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    dp = '0;
    num_errors = 0;
    checked = 0;
    n = '0;
    void'($urandom(32'hE23E83E3));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(32'(flags_out), 32'h0);
    // Pointers keep data, bit seven always reads one
    d = 8'($urandom);
    wr(CSRS_IDX_MP0, d);
    rdc(CSRS_IDX_MP0, d | 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      a = CSRS_GP_BASE + 8'($urandom_range(0, 63));
      d = 8'($urandom);
      wr(i[0] ? CSRS_IDX_MP1 : CSRS_IDX_MP0, a);
      wr(i[0] ? CSRS_IDX_IND1 : CSRS_IDX_IND0, d);
      rdc(a, d);
      rdc(i[0] ? CSRS_IDX_IND1 : CSRS_IDX_IND0, d);
    end
    // Port aimed at the other port: reads zero, write lost
    wr(CSRS_IDX_MP1, CSRS_IDX_IND0);
    rdc(CSRS_IDX_IND1, 8'h00);
    wr(CSRS_IDX_IND1, ~d);
    rdc(a, d);
    // First port aimed at the second: reads zero as well
    wr(CSRS_IDX_MP0, CSRS_IDX_IND1);
    rdc(CSRS_IDX_IND0, 8'h00);
    // System flags: bus writes cannot reach them
    wr(CSRS_IDX_FLAGS, 8'hFF);
    rdc(CSRS_IDX_FLAGS, 8'h0F);
    sys(1'b1, 1'b0, 1'b0, 8'h1F);
    sys(1'b0, 1'b1, 1'b0, 8'h3F);
    wr(CSRS_IDX_FLAGS, 8'h00);
    rdc(CSRS_IDX_FLAGS, 8'h30);
    sys(1'b1, 1'b0, 1'b0, 8'h10);
    sys(1'b0, 1'b1, 1'b0, 8'h30);
    sys(1'b0, 1'b0, 1'b1, 8'h00);
    // ALU ops cycle through codes one to seven (not NONE); add/sub corners first
    for (int i = 0; i < 42; i++)
    begin
      s = '0;
      s.op = csrs_op_e'(3'(i % 7 + 1));
      s.operand = 8'($urandom);
      a = 8'($urandom);
      if (i < 14 && i % 7 < 2)
        {a, s.operand} = ctab[(i / 7) * 2 + i % 7];
      e = alu(s.op, a, s.operand, 4'($urandom));
      wr(CSRS_IDX_ACC, a);
      wr(CSRS_IDX_FLAGS, 8'(e[11:8] ^ 4'hF) & 8'h00 | 8'($urandom) & 8'h00);
      wr(CSRS_IDX_FLAGS, 8'(alu(CSRS_OP_NONE, a, a, 4'h0) >> 8) | 8'(n));
      n = 32'($urandom) & 32'h0F;
      wr(CSRS_IDX_FLAGS, 8'(n));
      e = alu(s.op, a, s.operand, n[3:0]);
      dp_go(s);
      chk(32'(acc_out), 32'(e[7:0]));
      chk(32'(flags_out), 32'(e[11:8]));
    end
    // Accumulator stored directly and through a pointer
    d = 8'($urandom);
    wr(CSRS_IDX_ACC, d);
    wr(CSRS_IDX_MP0, 8'h51);
    s = '0;
    s.store_go = 1'b1;
    s.store_idx = 8'h50;
    dp_go(s);
    s.store_idx = CSRS_IDX_IND0;
    dp_go(s);
    rdc(8'h50, d);
    rdc(8'h51, d);
    // Table read: high byte latched, low byte stored
    w = 16'($urandom);
    wr(CSRS_IDX_TABLE_PTR_LOW, w[7:0]);
    wr(CSRS_IDX_TABLE_PTR_HIGH, w[15:8]);
    s = '0;
    s.tbl_go = 1'b1;
    s.tbl_idx = 8'h60;
    dp_go(s);
    chk(32'(pm_addr), 32'(w));
    wr(CSRS_IDX_TABLE_DATA_HIGH, 8'(~pm_word(w) >> 8));
    rdc(CSRS_IDX_TABLE_DATA_HIGH, 8'(pm_word(w) >> 8));
    rdc(8'h60, 8'(pm_word(w)));
    // Step past a page, then jump within it via the low byte
    s = '0;
    s.pc_step = 1'b1;
    @(posedge hclk);
    dp <= s;
    repeat (300) @(posedge hclk);
    dp <= '0;
    #1;
    chk(32'(pc_out), 32'd300);
    wr(CSRS_IDX_PCL, d);
    n = '0;
    repeat (3)
    begin
      #1;
      n = n + 32'(dummy_cycle);
      @(posedge hclk);
    end
    chk(n, 32'd1);
    chk(32'(pc_out), {19'h0, 5'h01, d});
    // Out-of-map access: write lost, read zero, response OKAY
    bus(1'b1, 32'h400 | ad(CSRS_IDX_FLAGS), 8'h0F ^ 8'(e[11:8]));
    rdc(CSRS_IDX_FLAGS, 8'(e[11:8]));
    bus(1'b0, 32'h400 | ad(CSRS_IDX_FLAGS), 8'h00);
    chk(rv, 32'h0);
    chk(32'(hresp), 32'h0);
    finish_test();
  end
endmodule // test_cpu_special_regs_status
